// ==== src/pptu_pkg.sv ====
package pptu_pkg;
  // register indices; each register owns one aligned word, byte address is four times the index
  localparam logic [7:0] PPTU_IDX_ASYM = 8'h04;
  localparam logic [7:0] PPTU_IDX_REQ_HI = 8'h08;
  localparam logic [7:0] PPTU_IDX_REQ_LO = 8'h0a;
  localparam logic [7:0] PPTU_IDX_SYNC_HI = 8'h0c;
  localparam logic [7:0] PPTU_IDX_SYNC_LO = 8'h0e;
  localparam logic [7:0] PPTU_IDX_RESP_HI = 8'h10;
  localparam logic [7:0] PPTU_IDX_RESP_LO = 8'h12;
  localparam logic [7:0] PPTU_IDX_FLAGS = 8'h14;
  localparam logic [7:0] PPTU_IDX_ENABLE = 8'h16;
  localparam logic [7:0] PPTU_ADDR_ASYM = {PPTU_IDX_ASYM[5:0], 2'h0};
  localparam logic [7:0] PPTU_ADDR_REQ_HI = {PPTU_IDX_REQ_HI[5:0], 2'h0};
  localparam logic [7:0] PPTU_ADDR_REQ_LO = {PPTU_IDX_REQ_LO[5:0], 2'h0};
  localparam logic [7:0] PPTU_ADDR_SYNC_HI = {PPTU_IDX_SYNC_HI[5:0], 2'h0};
  localparam logic [7:0] PPTU_ADDR_SYNC_LO = {PPTU_IDX_SYNC_LO[5:0], 2'h0};
  localparam logic [7:0] PPTU_ADDR_RESP_HI = {PPTU_IDX_RESP_HI[5:0], 2'h0};
  localparam logic [7:0] PPTU_ADDR_RESP_LO = {PPTU_IDX_RESP_LO[5:0], 2'h0};
  localparam logic [7:0] PPTU_ADDR_FLAGS = {PPTU_IDX_FLAGS[5:0], 2'h0};
  localparam logic [7:0] PPTU_ADDR_ENABLE = {PPTU_IDX_ENABLE[5:0], 2'h0};
  localparam int PPTU_SIGN_BIT = 15;
  localparam int PPTU_SYNC_BIT = 15;
  localparam int PPTU_REQ_BIT = 14;
  localparam int PPTU_RESP_BIT = 13;
  localparam logic [15:0] PPTU_REG_RESET = 16'h0000;
  localparam logic [15:0] PPTU_FLAG_MASK = 16'he000;
  localparam logic [1:0] PPTU_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PPTU_HTRANS_SEQ = 2'h3;
  localparam logic [2:0] PPTU_HSIZE_WORD = 3'h2;
  localparam int PPTU_CF_W = 64;
  // kinds of event frame seen by the correction path
  typedef enum logic [3:0] {
    PPTU_FR_SYNC_IN = 4'h1,
    PPTU_FR_RESP_IN = 4'h2,
    PPTU_FR_REQ_OUT = 4'h4,
    PPTU_FR_OTHER = 4'h8
  } pptu_frame_e;
endpackage

// ==== src/pptu_corr.sv ====
`timescale 1ns/1ps
`default_nettype none
module pptu_corr (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // asymmetry setting
  input wire logic asymmetry_negative,
  input wire logic [14:0] asymmetry_magnitude_ns,
  // frame in
  input wire logic cf_valid,
  input wire pptu_pkg::pptu_frame_e cf_kind,
  input wire logic [pptu_pkg::PPTU_CF_W-1:0] cf_in,
  // corrected frame field out
  output logic cf_out_valid,
  output logic [pptu_pkg::PPTU_CF_W-1:0] cf_out
);
  import pptu_pkg::*;
  typedef struct packed {
    logic vld;
    logic [PPTU_CF_W-1:0] cf;
  } pptu_corr_s;
  pptu_corr_s st_r, st_nxt;
  logic signed [PPTU_CF_W-1:0] asym_s;

  always_comb begin
    // sign-magnitude to two's complement
    asym_s = asymmetry_negative ? -$signed({49'h0, asymmetry_magnitude_ns})
                                : $signed({49'h0, asymmetry_magnitude_ns});
    st_nxt.vld = cf_valid;
    st_nxt.cf = cf_in;
    case (cf_kind)
      PPTU_FR_SYNC_IN, PPTU_FR_RESP_IN: st_nxt.cf = cf_in + asym_s;
      PPTU_FR_REQ_OUT: st_nxt.cf = cf_in - asym_s;
      default: st_nxt.cf = cf_in;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cf_out_valid = st_r.vld;
  assign cf_out = st_r.cf;

  chk_sub_request: assert property (@(posedge clk) disable iff (rst)
    cf_valid && cf_kind == PPTU_FR_REQ_OUT |=> cf_out == $past(cf_in) - $past(asym_s))
    else $error("request correction wrong");
  chk_add_sync: assert property (@(posedge clk) disable iff (rst)
    cf_valid && cf_kind == PPTU_FR_SYNC_IN |=> cf_out == $past(cf_in) + $past(asym_s))
    else $error("sync correction wrong");
endmodule
`default_nettype wire

// ==== src/pptu_top.sv ====
// Behaviour
// - bit 15 of asymmetry register is the sign, one means negative, resets zero
// - bits 14:0 hold a readable writable asymmetry magnitude in ns
// - ingress sync and response frames get asymmetry added to correction field
// - egress request frames get asymmetry subtracted from correction field
// - request egress time captured, high and low halves read-only, reset zero
// - sync egress time captured, high and low halves read-only, reset zero
// - response egress time captured, high and low halves read-only, reset zero
// - status bit 15 set on sync time capture, write one clears
// - status bit 14 set on request time capture, write one clears
// - status bit 13 set on response time capture, write one clears
// - interrupt status output is OR of the three flags
// - enable bits 15,14,13; their OR is the interrupt enable output
`timescale 1ns/1ps
`default_nettype none
module pptu_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // egress timestamp events from the port transmit path
  input wire logic [31:0] egress_time_ns,
  input wire logic sync_sent,
  input wire logic request_sent,
  input wire logic response_sent,
  // correction field path
  input wire logic cf_valid,
  input wire pptu_pkg::pptu_frame_e cf_kind,
  input wire logic [pptu_pkg::PPTU_CF_W-1:0] cf_in,
  output logic cf_out_valid,
  output logic [pptu_pkg::PPTU_CF_W-1:0] cf_out,
  // port interrupt indications
  output logic ptp_int_status,
  output logic ptp_int_enable
);
  import pptu_pkg::*;

  typedef struct packed {
    logic asymmetry_negative;
    logic [14:0] asymmetry_magnitude_ns;
    logic [31:0] request_egress_time;
    logic [31:0] sync_egress_time;
    logic [31:0] response_egress_time;
    logic sync_time_ready_flag;
    logic request_time_ready_flag;
    logic response_time_ready_flag;
    logic sync_time_ready_en;
    logic request_time_ready_en;
    logic response_time_ready_en;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } pptu_state_s;

  pptu_state_s st_r, st_nxt;
  logic addr_ok;
  logic [15:0] rd_word;
  logic [15:0] wd;

  function automatic logic [15:0] pptu_read(input pptu_state_s s, input logic [7:0] a);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      PPTU_ADDR_ASYM: v = {s.asymmetry_negative, s.asymmetry_magnitude_ns};
      PPTU_ADDR_REQ_HI: v = s.request_egress_time[31:16];
      PPTU_ADDR_REQ_LO: v = s.request_egress_time[15:0];
      PPTU_ADDR_SYNC_HI: v = s.sync_egress_time[31:16];
      PPTU_ADDR_SYNC_LO: v = s.sync_egress_time[15:0];
      PPTU_ADDR_RESP_HI: v = s.response_egress_time[31:16];
      PPTU_ADDR_RESP_LO: v = s.response_egress_time[15:0];
      // reserved bits stay zero
      PPTU_ADDR_FLAGS: v = {s.sync_time_ready_flag, s.request_time_ready_flag,
                            s.response_time_ready_flag, 13'h0000};
      PPTU_ADDR_ENABLE: v = {s.sync_time_ready_en, s.request_time_ready_en,
                             s.response_time_ready_en, 13'h0000};
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  function automatic logic pptu_known(input logic [7:0] a);
    logic k;
    k = 1'b0;
    case (a)
      PPTU_ADDR_ASYM, PPTU_ADDR_REQ_HI, PPTU_ADDR_REQ_LO, PPTU_ADDR_SYNC_HI,
      PPTU_ADDR_SYNC_LO, PPTU_ADDR_RESP_HI, PPTU_ADDR_RESP_LO, PPTU_ADDR_FLAGS,
      PPTU_ADDR_ENABLE: k = 1'b1;
      default: k = 1'b0;
    endcase
    return k;
  endfunction

  always_comb begin
    st_nxt = st_r;
    addr_ok = hsel && hready && (htrans == PPTU_HTRANS_NONSEQ || htrans == PPTU_HTRANS_SEQ);
    wd = hwdata[15:0];
    rd_word = pptu_read(st_r, haddr);
    // read data sampled at address phase; unmapped reads zero
    st_nxt.rdata = {16'h0000, (addr_ok && !hwrite && pptu_known(haddr)) ? rd_word : PPTU_REG_RESET};
    st_nxt.wr_pend = addr_ok && hwrite;
    st_nxt.wr_addr = haddr;
    // capture on each transmit event; a new event overwrites the old time
    if (request_sent) begin
      st_nxt.request_egress_time = egress_time_ns;
    end
    if (sync_sent) begin
      st_nxt.sync_egress_time = egress_time_ns;
    end
    if (response_sent) begin
      st_nxt.response_egress_time = egress_time_ns;
    end
    if (st_r.wr_pend) begin
      case (st_r.wr_addr)
        PPTU_ADDR_ASYM: begin
          st_nxt.asymmetry_negative = wd[PPTU_SIGN_BIT];
          st_nxt.asymmetry_magnitude_ns = wd[14:0];
        end
        PPTU_ADDR_FLAGS: begin
          // write one clears; reserved bits ignored
          if (wd[PPTU_SYNC_BIT]) begin
            st_nxt.sync_time_ready_flag = 1'b0;
          end
          if (wd[PPTU_REQ_BIT]) begin
            st_nxt.request_time_ready_flag = 1'b0;
          end
          if (wd[PPTU_RESP_BIT]) begin
            st_nxt.response_time_ready_flag = 1'b0;
          end
        end
        PPTU_ADDR_ENABLE: begin
          st_nxt.sync_time_ready_en = wd[PPTU_SYNC_BIT];
          st_nxt.request_time_ready_en = wd[PPTU_REQ_BIT];
          st_nxt.response_time_ready_en = wd[PPTU_RESP_BIT];
        end
        default: begin
        end
      endcase
    end
    // set after clear so a coincident event is not lost
    if (sync_sent) begin
      st_nxt.sync_time_ready_flag = 1'b1;
    end
    if (request_sent) begin
      st_nxt.request_time_ready_flag = 1'b1;
    end
    if (response_sent) begin
      st_nxt.response_time_ready_flag = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // zero-wait slave
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign ptp_int_status = st_r.sync_time_ready_flag | st_r.request_time_ready_flag
                        | st_r.response_time_ready_flag;
  assign ptp_int_enable = st_r.sync_time_ready_en | st_r.request_time_ready_en
                        | st_r.response_time_ready_en;

  pptu_corr u_corr (
    .clk(clk),
    .rst(rst),
    .asymmetry_negative(st_r.asymmetry_negative),
    .asymmetry_magnitude_ns(st_r.asymmetry_magnitude_ns),
    .cf_valid(cf_valid),
    .cf_kind(cf_kind),
    .cf_in(cf_in),
    .cf_out_valid(cf_out_valid),
    .cf_out(cf_out)
  );

  sequence s_flags_write(logic [15:0] m);
    st_r.wr_pend && st_r.wr_addr == PPTU_ADDR_FLAGS && (hwdata[15:0] & m) != 16'h0000;
  endsequence

  // address phase of a write, as the slave takes it
  sequence s_write_addr(logic [7:0] a);
    addr_ok && hwrite && haddr == a;
  endsequence

  // data phase of a write, one cycle after its address phase
  sequence s_write_data(logic [7:0] a);
    st_r.wr_pend && st_r.wr_addr == a;
  endsequence

  // address phase of a read
  sequence s_read_addr(logic [7:0] a);
    addr_ok && !hwrite && haddr == a;
  endsequence

  // no transmit event this cycle
  sequence s_no_event;
    !sync_sent && !request_sent && !response_sent;
  endsequence

  chk_sync_set: assert property (@(posedge clk) disable iff (rst)
    sync_sent |=> st_r.sync_time_ready_flag && st_r.sync_egress_time == $past(egress_time_ns))
    else $error("sync flag or time not captured");
  chk_req_set: assert property (@(posedge clk) disable iff (rst)
    request_sent |=> st_r.request_time_ready_flag && st_r.request_egress_time == $past(egress_time_ns))
    else $error("request flag or time not captured");
  chk_resp_set: assert property (@(posedge clk) disable iff (rst)
    response_sent |=> st_r.response_time_ready_flag
      && st_r.response_egress_time == $past(egress_time_ns))
    else $error("response flag or time not captured");
  chk_sync_clear: assert property (@(posedge clk) disable iff (rst)
    s_flags_write(16'h8000) and !sync_sent |=> !st_r.sync_time_ready_flag)
    else $error("sync flag not cleared");
  chk_req_clear: assert property (@(posedge clk) disable iff (rst)
    s_flags_write(16'h4000) and !request_sent |=> !st_r.request_time_ready_flag)
    else $error("request flag not cleared");
  chk_resp_clear: assert property (@(posedge clk) disable iff (rst)
    s_flags_write(16'h2000) and !response_sent |=> !st_r.response_time_ready_flag)
    else $error("response flag not cleared");
  chk_int_or: assert property (@(posedge clk) disable iff (rst)
    sync_sent || request_sent || response_sent |=> ptp_int_status)
    else $error("interrupt status not raised by a flag");
  // a full clear with no coincident event must drop the status
  chk_int_clear: assert property (@(posedge clk) disable iff (rst)
    s_write_data(PPTU_ADDR_FLAGS) and s_no_event and hwdata[15:13] == 3'h7 |=> !ptp_int_status)
    else $error("interrupt status not dropped by clear");
  chk_en_write: assert property (@(posedge clk) disable iff (rst)
    s_write_data(PPTU_ADDR_ENABLE) |=> ptp_int_enable == (|$past(hwdata[15:13])))
    else $error("interrupt enable not OR of enable bits");
  chk_en_hold: assert property (@(posedge clk) disable iff (rst)
    !(st_r.wr_pend && st_r.wr_addr == PPTU_ADDR_ENABLE) |=> $stable(ptp_int_enable))
    else $error("interrupt enable moved without a write");
  // captured times move only on their own event; bus writes never reach them
  chk_req_hold: assert property (@(posedge clk) disable iff (rst)
    !request_sent |=> $stable(st_r.request_egress_time))
    else $error("request time moved without event");
  chk_sync_hold: assert property (@(posedge clk) disable iff (rst)
    !sync_sent |=> $stable(st_r.sync_egress_time))
    else $error("sync time moved without event");
  chk_resp_hold: assert property (@(posedge clk) disable iff (rst)
    !response_sent |=> $stable(st_r.response_egress_time))
    else $error("response time moved without event");
  chk_asym_hold: assert property (@(posedge clk) disable iff (rst)
    !(st_r.wr_pend && st_r.wr_addr == PPTU_ADDR_ASYM)
      |=> $stable({st_r.asymmetry_negative, st_r.asymmetry_magnitude_ns}))
    else $error("asymmetry moved without a write");
  // flags are sticky until software writes one to them
  chk_sync_sticky: assert property (@(posedge clk) disable iff (rst)
    st_r.sync_time_ready_flag
      && !(st_r.wr_pend && st_r.wr_addr == PPTU_ADDR_FLAGS && hwdata[PPTU_SYNC_BIT])
      |=> st_r.sync_time_ready_flag)
    else $error("sync flag lost without clear");
  chk_req_sticky: assert property (@(posedge clk) disable iff (rst)
    st_r.request_time_ready_flag
      && !(st_r.wr_pend && st_r.wr_addr == PPTU_ADDR_FLAGS && hwdata[PPTU_REQ_BIT])
      |=> st_r.request_time_ready_flag)
    else $error("request flag lost without clear");
  chk_resp_sticky: assert property (@(posedge clk) disable iff (rst)
    st_r.response_time_ready_flag
      && !(st_r.wr_pend && st_r.wr_addr == PPTU_ADDR_FLAGS && hwdata[PPTU_RESP_BIT])
      |=> st_r.response_time_ready_flag)
    else $error("response flag lost without clear");
  // read data stands in the data phase and shows the state at the address phase
  chk_read_asym: assert property (@(posedge clk) disable iff (rst)
    s_read_addr(PPTU_ADDR_ASYM)
      |=> hrdata == {16'h0000, $past(st_r.asymmetry_negative), $past(st_r.asymmetry_magnitude_ns)})
    else $error("asymmetry read wrong");
  chk_read_req_hi: assert property (@(posedge clk) disable iff (rst)
    s_read_addr(PPTU_ADDR_REQ_HI) |=> hrdata == {16'h0000, $past(st_r.request_egress_time[31:16])})
    else $error("request high read wrong");
  chk_read_req_lo: assert property (@(posedge clk) disable iff (rst)
    s_read_addr(PPTU_ADDR_REQ_LO) |=> hrdata == {16'h0000, $past(st_r.request_egress_time[15:0])})
    else $error("request low read wrong");
  chk_read_sync_hi: assert property (@(posedge clk) disable iff (rst)
    s_read_addr(PPTU_ADDR_SYNC_HI) |=> hrdata == {16'h0000, $past(st_r.sync_egress_time[31:16])})
    else $error("sync high read wrong");
  chk_read_sync_lo: assert property (@(posedge clk) disable iff (rst)
    s_read_addr(PPTU_ADDR_SYNC_LO) |=> hrdata == {16'h0000, $past(st_r.sync_egress_time[15:0])})
    else $error("sync low read wrong");
  chk_read_resp_hi: assert property (@(posedge clk) disable iff (rst)
    s_read_addr(PPTU_ADDR_RESP_HI) |=> hrdata == {16'h0000, $past(st_r.response_egress_time[31:16])})
    else $error("response high read wrong");
  chk_read_resp_lo: assert property (@(posedge clk) disable iff (rst)
    s_read_addr(PPTU_ADDR_RESP_LO) |=> hrdata == {16'h0000, $past(st_r.response_egress_time[15:0])})
    else $error("response low read wrong");
  chk_read_flags: assert property (@(posedge clk) disable iff (rst)
    s_read_addr(PPTU_ADDR_FLAGS) |=> hrdata[15:13] == $past({st_r.sync_time_ready_flag,
      st_r.request_time_ready_flag, st_r.response_time_ready_flag}))
    else $error("flag read wrong");
  // unmapped places read zero so software can probe safely
  chk_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
    addr_ok && !hwrite && !pptu_known(haddr) |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  // a write takes effect two cycles after its address phase
  chk_asym_land: assert property (@(posedge clk) disable iff (rst)
    s_write_addr(PPTU_ADDR_ASYM) ##1 1'b1 |=> {st_r.asymmetry_negative, st_r.asymmetry_magnitude_ns}
      == $past(hwdata[15:0]))
    else $error("asymmetry write did not land");
  chk_reserved_write: assert property (@(posedge clk) disable iff (rst)
    s_write_data(PPTU_ADDR_FLAGS) and s_no_event and hwdata[15:13] == 3'h0 |=> $stable(ptp_int_status))
    else $error("flag write without set bits changed status");
  chk_asym_write: assert property (@(posedge clk) disable iff (rst)
    st_r.wr_pend && st_r.wr_addr == PPTU_ADDR_ASYM |=>
      {st_r.asymmetry_negative, st_r.asymmetry_magnitude_ns} == $past(hwdata[15:0]))
    else $error("asymmetry write lost");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    addr_ok && !hwrite && haddr == PPTU_ADDR_FLAGS |=> hrdata[12:0] == 13'h0000)
    else $error("reserved status bits not zero");
endmodule
`default_nettype wire

// ==== bench/pptu_testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pptu_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = PPTU_HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] egress_time_ns = 32'h0;
  logic sync_sent = 1'b0;
  logic request_sent = 1'b0;
  logic response_sent = 1'b0;
  logic cf_valid = 1'b0;
  pptu_frame_e cf_kind = PPTU_FR_OTHER;
  logic [63:0] cf_in = 64'h0;
  wire logic hready;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic cf_out_valid;
  wire logic [63:0] cf_out;
  wire logic ptp_int_status;
  wire logic ptp_int_enable;
  logic [31:0] seed = 32'ha836;
  logic [31:0] rd;
  logic [31:0] d;
  logic [15:0] asym = 16'h0;
  logic [15:0] flags = 16'h0;
  logic [31:0] ts [3];
  int k;
  int fail_count = 0;
  int checked = 0;
  logic [7:0] ts_addr [6] = '{PPTU_ADDR_SYNC_HI, PPTU_ADDR_SYNC_LO, PPTU_ADDR_REQ_HI, PPTU_ADDR_REQ_LO,
    PPTU_ADDR_RESP_HI, PPTU_ADDR_RESP_LO};
  logic [7:0] all_addr [9] = '{PPTU_ADDR_ASYM, PPTU_ADDR_REQ_HI, PPTU_ADDR_REQ_LO, PPTU_ADDR_SYNC_HI,
    PPTU_ADDR_SYNC_LO, PPTU_ADDR_RESP_HI, PPTU_ADDR_RESP_LO, PPTU_ADDR_FLAGS, PPTU_ADDR_ENABLE};
  pptu_frame_e kinds [4] = '{PPTU_FR_SYNC_IN, PPTU_FR_RESP_IN, PPTU_FR_REQ_OUT, PPTU_FR_OTHER};
  logic [15:0] corner [3] = '{16'h8000, 16'hffff, 16'h7fff};
  // single slave: its ready closes the loop
  assign hready = hreadyout;
  always #5 clk = ~clk;
  pptu_top uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .egress_time_ns(egress_time_ns), .sync_sent(sync_sent), .request_sent(request_sent),
    .response_sent(response_sent), .cf_valid(cf_valid), .cf_kind(cf_kind), .cf_in(cf_in),
    .cf_out_valid(cf_out_valid), .cf_out(cf_out), .ptp_int_status(ptp_int_status),
    .ptp_int_enable(ptp_int_enable));
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // signed correction: sign bit selects negation of the 15-bit magnitude
  function automatic logic [63:0] cf_exp(pptu_frame_e kd, logic [63:0] v, logic [15:0] a);
    logic [63:0] m;
    m = a[15] ? -{49'h0, a[14:0]} : {49'h0, a[14:0]};
    case (kd)
      PPTU_FR_SYNC_IN, PPTU_FR_RESP_IN: return v + m;
      PPTU_FR_REQ_OUT: return v - m;
      default: return v;
    endcase
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // entered just after a rising edge; returns at the edge that ends the data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= PPTU_HTRANS_NONSEQ;
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
    q = hrdata;
    chk(hresp, 1'b0);
  endtask
  task automatic ev(input int kk, input logic [31:0] t);
    egress_time_ns <= t;
    sync_sent <= (kk == 0);
    request_sent <= (kk == 1);
    response_sent <= (kk == 2);
    @(posedge clk);
    sync_sent <= 1'b0;
    request_sent <= 1'b0;
    response_sent <= 1'b0;
    // time moves on so a late capture shows
    egress_time_ns <= ~t;
    @(posedge clk);
    ts[kk] = t;
    flags[15-kk] = 1'b1;
  endtask
  task automatic cf(input pptu_frame_e kd, input logic [63:0] v);
    cf_valid <= 1'b1;
    cf_kind <= kd;
    cf_in <= v;
    @(posedge clk);
    cf_valid <= 1'b0;
    #1;
    chk(cf_out_valid, 1'b1);
    chk(cf_out, cf_exp(kd, v, asym));
    @(posedge clk);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (all_addr[i]) begin
      bus(all_addr[i], 1'b0, 32'h0, rd);
      chk(rd, 32'h0);
    end
    chk(ptp_int_status, 1'b0);
    chk(ptp_int_enable, 1'b0);
    for (int i = 0; i < 8; i++) begin
      d = (i < 3) ? {16'h0, corner[i]} : rnd();
      bus(PPTU_ADDR_ASYM, 1'b1, d, rd);
      asym = d[15:0];
      bus(PPTU_ADDR_ASYM, 1'b0, 32'h0, rd);
      chk(rd, {16'h0, asym});
      foreach (kinds[j]) cf(kinds[j], {rnd(), rnd()});
    end
    for (int i = 0; i < 9; i++) begin
      k = i % 3;
      ev(k, rnd());
      // writes to the captured time must not stick
      bus(ts_addr[2*k], 1'b1, rnd(), rd);
      bus(ts_addr[2*k], 1'b0, 32'h0, rd);
      chk(rd, {16'h0, ts[k][31:16]});
      bus(ts_addr[2*k+1], 1'b0, 32'h0, rd);
      chk(rd, {16'h0, ts[k][15:0]});
      bus(PPTU_ADDR_FLAGS, 1'b0, 32'h0, rd);
      chk(rd, {16'h0, flags});
      chk(ptp_int_status, |flags);
      if (i >= 3) begin
        d = rnd();
        bus(PPTU_ADDR_FLAGS, 1'b1, d, rd);
        flags = flags & ~(d[15:0] & PPTU_FLAG_MASK);
      end
    end
    bus(PPTU_ADDR_FLAGS, 1'b1, 32'hffff_ffff, rd);
    bus(PPTU_ADDR_FLAGS, 1'b0, 32'h0, rd);
    chk(rd, 32'h0);
    chk(ptp_int_status, 1'b0);
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0000_1fff : rnd();
      bus(PPTU_ADDR_ENABLE, 1'b1, d, rd);
      bus(PPTU_ADDR_ENABLE, 1'b0, 32'h0, rd);
      chk(rd, {16'h0, d[15:0] & PPTU_FLAG_MASK});
      chk(ptp_int_enable, |d[15:13]);
    end
    // unmapped place: reads zero, write lands nowhere
    bus(8'h7c, 1'b1, rnd(), rd);
    bus(8'h7c, 1'b0, 32'h0, rd);
    chk(rd, 32'h0);
    bus(PPTU_ADDR_ASYM, 1'b0, 32'h0, rd);
    chk(rd, {16'h0, asym});
    test_done();
  end
  // whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
